/* src/timer_ctl_pkg.sv */
// constants for the 8-bit timer control block
// assumes one system clock and an 8-bit cpu register port
package timer_ctl_pkg;

    localparam int DATA_W = 8;
    localparam int PRE_W = 10;

    // register addresses
    localparam logic [7:0] ADDR_CTL = 8'h_E2;
    localparam logic [7:0] ADDR_CNT = 8'h_E4;
    localparam logic [7:0] ADDR_DATA = 8'h_E5;
    localparam logic [7:0] ADDR_PEND = 8'h_E6;
    localparam logic [7:0] ADDR_MASK = 8'h_E7;

    // control register fields and reset
    localparam logic [7:0] CTL_RESET = 8'h_00;
    localparam int CTL_SEL_HI = 7;
    localparam int CTL_SEL_LO = 5;
    localparam int CTL_MODE_HI = 4;
    localparam int CTL_MODE_LO = 3;
    localparam int CTL_CLR_BIT = 2;
    localparam int CTL_MIE_BIT = 1;
    localparam int CTL_OIE_BIT = 0;

    // pending and mask register bits
    localparam int PEND_OVF_BIT = 0;
    localparam int PEND_MCH_BIT = 1;
    localparam int MASK_AUTO_BIT = 0;

    localparam logic [7:0] ZERO8 = 8'h_00;
    localparam logic [7:0] MAX8 = 8'h_FF;
    localparam logic [7:0] ONE8 = 8'h_01;

    // clock select codes
    localparam logic [2:0] SEL_DIV1024 = 3'h_0;
    localparam logic [2:0] SEL_DIV256 = 3'h_1;
    localparam logic [2:0] SEL_DIV64 = 3'h_2;
    localparam logic [2:0] SEL_DIV8 = 3'h_3;
    localparam logic [2:0] SEL_DIV1 = 3'h_4;
    localparam logic [2:0] SEL_EXT_FALL = 3'h_5;
    localparam logic [2:0] SEL_EXT_RISE = 3'h_6;
    localparam logic [2:0] SEL_STOP = 3'h_7;

    // divider terminal values
    localparam logic [PRE_W-1:0] MSK_1024 = 10'h_3FF;
    localparam logic [PRE_W-1:0] MSK_256 = 10'h_0FF;
    localparam logic [PRE_W-1:0] MSK_64 = 10'h_03F;
    localparam logic [PRE_W-1:0] MSK_8 = 10'h_007;
    localparam logic [PRE_W-1:0] PRE_ONE = 10'h_001;
    localparam logic [PRE_W-1:0] PRE_ZERO = 10'h_000;

    // operating modes
    localparam logic [1:0] MODE_INTERVAL = 2'h_0;
    localparam logic [1:0] MODE_CAP_RISE = 2'h_1;
    localparam logic [1:0] MODE_CAP_FALL = 2'h_2;
    localparam logic [1:0] MODE_PWM = 2'h_3;

    localparam int PIN_EXT = 0;
    localparam int PIN_CAP = 1;
    localparam int NUM_PINS = 2;

endpackage

/* src/count_prescaler.sv */
// counter clock source: system clock divider and select mux
// assumes edge pulses of the external pin come already synchronised
`timescale 1ns/1ps
module count_prescaler
    import timer_ctl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [2:0] sel_i,
    input wire logic ext_rise_i,
    input wire logic ext_fall_i,
    output logic tick_o
);

    typedef struct packed {
        logic [PRE_W-1:0] div;
    } pre_state_t;

    pre_state_t st_r;
    pre_state_t st_nxt;

    function automatic logic at_end(input logic [PRE_W-1:0] d,
                                    input logic [PRE_W-1:0] m);
        at_end = ((d & m) == m);
    endfunction

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        st_nxt.div = st_r.div + PRE_ONE;
        tick_o = 1'b0;
        case (sel_i)
            SEL_DIV1024: tick_o = at_end(st_r.div, MSK_1024);
            SEL_DIV256: tick_o = at_end(st_r.div, MSK_256);
            SEL_DIV64: tick_o = at_end(st_r.div, MSK_64);
            SEL_DIV8: tick_o = at_end(st_r.div, MSK_8);
            SEL_DIV1: tick_o = 1'b1;
            SEL_EXT_FALL: tick_o = ext_fall_i;
            SEL_EXT_RISE: tick_o = ext_rise_i;
            default: tick_o = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= '{div: PRE_ZERO};
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

endmodule // count_prescaler

/* src/eight_bit_timer_control.sv */
// 8-bit timer/counter: control register, counter, modes, pending flags
// assumes a cpu register port and service acknowledge pulses
`timescale 1ns/1ps
module eight_bit_timer_control
    import timer_ctl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic ovf_ack_i,
    input wire logic match_ack_i,
    input wire logic external_count_clock_pin_i,
    input wire logic capture_input_pin_i,
    output logic [7:0] reg_rdata_o,
    output logic overflow_interrupt_o,
    output logic match_capture_interrupt_o,
    output logic interrupt_level_zero_o,
    output logic match_toggle_output_o,
    output logic pulse_width_output_o
);

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] cnt;
        logic [7:0] ref_data;
        logic [1:0] pend;
        logic auto_clr;
        logic [NUM_PINS-1:0] s1;
        logic [NUM_PINS-1:0] s2;
        logic [NUM_PINS-1:0] s3;
        logic [NUM_PINS-1:0] filt;
        logic [7:0] rdata;
        logic ovf_irq;
        logic mch_irq;
        logic lvl0_irq;
        logic toggle;
        logic pwm;
    } timer_state_t;

    timer_state_t st_r;
    timer_state_t st_nxt;

    logic tick;
    logic [NUM_PINS-1:0] rise;
    logic [NUM_PINS-1:0] fall;
    logic [NUM_PINS-1:0] pins;
    logic [1:0] mode;
    logic wr_ctl;
    logic wr_data;
    logic wr_pend;
    logic wr_mask;
    logic cap_edge;
    logic match;
    logic ovf_evt;
    logic mch_evt;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] b);
        hit = (a == b);
    endfunction

    assign pins = {capture_input_pin_i, external_count_clock_pin_i};
    assign mode = st_r.ctl[CTL_MODE_HI:CTL_MODE_LO];

    ////////////////////////////////////////////////////////////////////
    // pin edges from the filtered level
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_edge
            assign rise[gi] = (st_r.s2[gi] == st_r.s3[gi]) &&
                              st_r.s3[gi] && !st_r.filt[gi];
            assign fall[gi] = (st_r.s2[gi] == st_r.s3[gi]) &&
                              !st_r.s3[gi] && st_r.filt[gi];
        end
    endgenerate

    count_prescaler u_pre (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .sel_i(st_r.ctl[CTL_SEL_HI:CTL_SEL_LO]),
        .ext_rise_i(rise[PIN_EXT]),
        .ext_fall_i(fall[PIN_EXT]),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // register write decode
    always_comb begin
        wr_ctl = 1'b0;
        wr_data = 1'b0;
        wr_pend = 1'b0;
        wr_mask = 1'b0;
        if (reg_wr_i && reg_addr_i == ADDR_CTL) begin
            wr_ctl = 1'b1;
        end else if (reg_wr_i && reg_addr_i == ADDR_DATA) begin
            wr_data = 1'b1;
        end else if (reg_wr_i && reg_addr_i == ADDR_PEND) begin
            wr_pend = 1'b1;
        end else if (reg_wr_i && reg_addr_i == ADDR_MASK) begin
            wr_mask = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // events
    always_comb begin
        cap_edge = 1'b0;
        if (mode == MODE_CAP_RISE) begin
            cap_edge = rise[PIN_CAP];
        end else if (mode == MODE_CAP_FALL) begin
            cap_edge = fall[PIN_CAP];
        end
        match = tick && hit(st_r.cnt, st_r.ref_data) &&
                (mode == MODE_INTERVAL || mode == MODE_PWM);
        ovf_evt = tick && !(match && mode == MODE_INTERVAL) &&
                  hit(st_r.cnt, MAX8);
        mch_evt = match || cap_edge;
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;

        // three-stage pin synchronisers
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.filt[i] = st_r.s3[i];
            end
        end

        // counter
        if (tick) begin
            if (match && mode == MODE_INTERVAL) begin
                st_nxt.cnt = ZERO8;
                st_nxt.toggle = !st_r.toggle;
            end else begin
                st_nxt.cnt = st_r.cnt + ONE8;
            end
        end

        // capture loads the reference register
        if (cap_edge) begin
            st_nxt.ref_data = st_r.cnt;
        end else if (wr_data) begin
            st_nxt.ref_data = reg_wdata_i;
        end

        // control register; clear bit never stored
        if (wr_ctl) begin
            st_nxt.ctl = reg_wdata_i;
            st_nxt.ctl[CTL_CLR_BIT] = 1'b0;
            if (reg_wdata_i[CTL_CLR_BIT]) begin
                st_nxt.cnt = ZERO8;
            end
        end

        if (wr_mask) begin
            st_nxt.auto_clr = reg_wdata_i[MASK_AUTO_BIT];
        end

        // overflow pending: cleared by service or software zero
        if (wr_pend && !reg_wdata_i[PEND_OVF_BIT]) begin
            st_nxt.pend[PEND_OVF_BIT] = 1'b0;
        end
        if (ovf_ack_i) begin
            st_nxt.pend[PEND_OVF_BIT] = 1'b0;
        end
        if (ovf_evt) begin
            st_nxt.pend[PEND_OVF_BIT] = 1'b1;
        end

        // match/capture pending
        if (wr_pend && !reg_wdata_i[PEND_MCH_BIT]) begin
            st_nxt.pend[PEND_MCH_BIT] = 1'b0;
        end
        if (match_ack_i && st_r.auto_clr &&
            st_r.ctl[CTL_MIE_BIT]) begin
            st_nxt.pend[PEND_MCH_BIT] = 1'b0;
        end
        if (mch_evt) begin
            st_nxt.pend[PEND_MCH_BIT] = 1'b1;
        end

        // interrupt requests
        st_nxt.ovf_irq = st_nxt.pend[PEND_OVF_BIT] &&
                         st_nxt.ctl[CTL_OIE_BIT];
        st_nxt.mch_irq = st_nxt.pend[PEND_MCH_BIT] &&
                         st_nxt.ctl[CTL_MIE_BIT];
        st_nxt.lvl0_irq = st_nxt.ovf_irq || st_nxt.mch_irq;

        // pwm output
        if (mode == MODE_PWM) begin
            st_nxt.pwm = (st_nxt.ref_data > st_nxt.cnt);
        end else begin
            st_nxt.pwm = 1'b0;
        end

        // read data
        if (reg_rd_i && reg_addr_i == ADDR_CTL) begin
            st_nxt.rdata = st_r.ctl;
        end else if (reg_rd_i && reg_addr_i == ADDR_CNT) begin
            st_nxt.rdata = st_r.cnt;
        end else if (reg_rd_i && reg_addr_i == ADDR_DATA) begin
            st_nxt.rdata = st_r.ref_data;
        end else if (reg_rd_i && reg_addr_i == ADDR_PEND) begin
            st_nxt.rdata = {6'h_00, st_r.pend};
        end else if (reg_rd_i && reg_addr_i == ADDR_MASK) begin
            st_nxt.rdata = {7'h_00, st_r.auto_clr};
        end else if (reg_rd_i) begin
            st_nxt.rdata = ZERO8;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
            st_r.ctl <= CTL_RESET;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign overflow_interrupt_o = st_r.ovf_irq;
    assign match_capture_interrupt_o = st_r.mch_irq;
    assign interrupt_level_zero_o = st_r.lvl0_irq;
    assign match_toggle_output_o = st_r.toggle;
    assign pulse_width_output_o = st_r.pwm;

endmodule // eight_bit_timer_control

/* tb/timer_ctl_assertions.sv */
// port checker for the 8-bit timer control block
// assumes bind onto the block top, one clock domain
`timescale 1ns/1ps
module timer_ctl_assertions
    import timer_ctl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic ovf_ack_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic overflow_interrupt_o,
    input wire logic match_capture_interrupt_o,
    input wire logic interrupt_level_zero_o,
    input wire logic match_toggle_output_o,
    input wire logic pulse_width_output_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_rd;
        ce_i && reg_rd_i;
    endsequence
    sequence s_rd_ctl;
        s_rd ##0 reg_addr_i == ADDR_CTL;
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_lvl_zero_or: assert property (interrupt_level_zero_o ==
        (overflow_interrupt_o | match_capture_interrupt_o))
        else $error("level zero request not the or of both");
    a_ovf_ack_clr: assert property (ce_i && ovf_ack_i |=>
        !overflow_interrupt_o) else $error("overflow kept after ack");
    a_clr_bit_zero: assert property (s_rd_ctl |=>
        reg_rdata_o[CTL_CLR_BIT] == 1'b0)
        else $error("clear bit reads one");
    a_reset_outs: assert property ($fell(sys_rst_i) |->
        !interrupt_level_zero_o && !match_toggle_output_o &&
        !pulse_width_output_o) else $error("outputs set after reset");
    a_toggle_pwm: assert property ($changed(match_toggle_output_o) |->
        !pulse_width_output_o)
        else $error("toggle moved outside interval mode");
    a_unmap_zero: assert property (s_rd ##0 reg_addr_i > ADDR_MASK
        |=> reg_rdata_o == ZERO8) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!(ce_i && reg_rd_i) |=>
        $stable(reg_rdata_o)) else $error("read data moved");
    a_ce_freeze: assert property (!ce_i |=> $stable({
        interrupt_level_zero_o, match_toggle_output_o,
        pulse_width_output_o})) else $error("state moved while frozen");
endmodule // timer_ctl_assertions
bind eight_bit_timer_control timer_ctl_assertions timer_ctl_assertions_i(
    .core_clk_i, .sys_rst_i, .ce_i, .reg_addr_i, .reg_rd_i, .ovf_ack_i,
    .reg_rdata_o, .overflow_interrupt_o, .match_capture_interrupt_o,
    .interrupt_level_zero_o, .match_toggle_output_o,
    .pulse_width_output_o);

/* tb/cpu_port_model.sv */
// cpu side of the register port: one access at a time
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/1ps
module cpu_port_model
    import timer_ctl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_wdata_o
);
    initial {reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = '0;
    // idle bus shows the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1 d = reg_rdata_i;
    endtask
endmodule // cpu_port_model

/* tb/eight_bit_timer_control_bench.sv */
// self-checking bench for the 8-bit timer control block
// assumes the cpu port model and the bound checker
`timescale 1ns/1ps
module eight_bit_timer_control_bench
    import timer_ctl_pkg::*;
;
    logic clk = 0, rst = 1, ce = 1, ext = 0, cap = 0;
    logic [1:0] ack = '0;
    logic [7:0] ad, wd, rdat, v;
    logic wr, rd, ovf, mint, lvl, tog, pwm;
    int failures = 0, checked = 0, togs = 0;
    initial forever #2 clk = ~clk;
    always @(tog) if (!rst) togs++;
    cpu_port_model cpu_port_model_i(.core_clk_i(clk), .reg_rdata_i(rdat),
        .reg_addr_o(ad), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wd));
    eight_bit_timer_control eight_bit_timer_control_i(.core_clk_i(clk),
        .sys_rst_i(rst), .ce_i(ce), .reg_addr_i(ad), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wd), .ovf_ack_i(ack[0]),
        .match_ack_i(ack[1]), .external_count_clock_pin_i(ext),
        .capture_input_pin_i(cap), .reg_rdata_o(rdat),
        .overflow_interrupt_o(ovf), .match_capture_interrupt_o(mint),
        .interrupt_level_zero_o(lvl), .match_toggle_output_o(tog),
        .pulse_width_output_o(pwm));
    ////////////////////////////////////////////////////////////////////
    task automatic check(string n, logic [7:0] s, logic [7:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic ackp(int b);
        @(posedge clk) ack[b] <= 1'b1;
        @(posedge clk) ack[b] <= 1'b0;
    endtask
    task automatic ext3();
        repeat (3) begin
            repeat (8) @(posedge clk);
            ext <= ~ext;
            repeat (8) @(posedge clk);
            ext <= ~ext;
        end
        repeat (8) @(posedge clk);
    endtask
    task automatic run(logic [7:0] c, int n);
        cpu_port_model_i.wr(ADDR_CTL, c);
        repeat (n) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        cpu_port_model_i.rd(ADDR_CTL, v);
        check("ctl", v, CTL_RESET);
        cpu_port_model_i.rd(8'h_F0, v);
        check("unmap", v, ZERO8);
        cpu_port_model_i.wr(ADDR_DATA, MAX8);
        run(8'h_64, 80);
        run(8'h_E0, 0);
        cpu_port_model_i.rd(ADDR_CNT, v);
        check("div8", 8'(v inside {[8'h_09:8'h_0B]}), ONE8);
        run(8'h_44, 200);
        run(8'h_E0, 0);
        cpu_port_model_i.rd(ADDR_CNT, v);
        check("div64", 8'(v inside {[8'h_03:8'h_04]}), ONE8);
        cpu_port_model_i.wr(ADDR_DATA, 8'h_05);
        run(8'h_86, 24);
        run(8'h_E2, 2);
        cpu_port_model_i.rd(ADDR_CNT, v);
        check("ivl", 8'(v <= 8'h_05), ONE8);
        check("togs", 8'(togs >= 3), ONE8);
        cpu_port_model_i.rd(ADDR_PEND, v);
        check("mpend", 8'(v[PEND_MCH_BIT]), ONE8);
        check("mint", 8'(lvl & mint), ONE8);
        ackp(1);
        @(posedge clk);
        check("noauto", 8'(mint), ONE8);
        cpu_port_model_i.wr(ADDR_PEND, ZERO8);
        cpu_port_model_i.rd(ADDR_PEND, v);
        check("swclr", v, ZERO8);
        run(8'h_86, 20);
        run(8'h_E2, 0);
        cpu_port_model_i.wr(ADDR_MASK, ONE8);
        ackp(1);
        @(posedge clk);
        check("auto", 8'(mint), ZERO8);
        run(8'h_E6, 2);
        cpu_port_model_i.rd(ADDR_CNT, v);
        check("clr", v, ZERO8);
        cpu_port_model_i.rd(ADDR_CTL, v);
        check("selfclr", v, 8'h_E2);
        run(8'h_C4, 0);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        ext3();
        cpu_port_model_i.rd(ADDR_CNT, v);
        check("extrise", v, 8'h_03);
        run(8'h_A4, 0);
        ext3();
        cpu_port_model_i.rd(ADDR_CNT, v);
        check("extfall", v, 8'h_03);
        for (int m = 1; m <= 2; m++) begin
            cpu_port_model_i.wr(ADDR_PEND, ZERO8);
            run(8'h_84 | 8'(m << 3), 4);
            cap <= ~cap;
            repeat (12) @(posedge clk);
            cpu_port_model_i.rd(ADDR_PEND, v);
            check("capture", 8'(v[PEND_MCH_BIT]), ONE8);
        end
        cpu_port_model_i.wr(ADDR_DATA, 8'h_80);
        run(8'h_9D, 300);
        check("ovf", 8'(ovf), ONE8);
        run(8'h_F9, 2);
        cpu_port_model_i.rd(ADDR_CNT, v);
        check("pwm", 8'(pwm), 8'(8'h_80 > v));
        ackp(0);
        cpu_port_model_i.rd(ADDR_PEND, v);
        check("ovfclr", 8'(v[PEND_OVF_BIT]), ZERO8);
        finish_test();
    end
endmodule // eight_bit_timer_control_bench
